// ---- design/acx_regs.vh ----
`ifndef ACX_REGS_VH
`define ACX_REGS_VH
// Operation selects presented on op_sel_i.
`define ACX_OP_NONE      3'h0
`define ACX_OP_AND_MEM   3'h1
`define ACX_OP_AND_IMM   3'h2
`define ACX_OP_AND_TO_M  3'h3
`define ACX_OP_CALL      3'h4
`define ACX_OP_CLR_MEM   3'h5
// Timing: one instruction cycle is four system clocks.
`define ACX_CLK_PER_ICYC 4
`define ACX_CALL_ICYC    2
`define ACX_BASE_ICYC    1
`define ACX_EXTRA_ICYC   1
// Reset values.
`define ACX_ACC_RST      8'h00
`define ACX_IP_RST       12'h000
`define ACX_ZERO_BYTE    8'h00
`endif

// ---- design/acx_stack.v ----
`timescale 1ns/10ps
`default_nettype none
// Hardware return stack; the top entry comes out of a register.
module acx_stack #(
    parameter AW    = 12,
    parameter DEPTH = 8,
    parameter PW    = 3
) (
    // Clock and reset.
    input  wire          clk_i,
    input  wire          arst_n_i,
    // Push port.
    input  wire          push_i,
    input  wire [AW-1:0] push_data_i,
    // Top of stack and pointer.
    output reg  [AW-1:0] top_ff,
    output reg  [PW-1:0] ptr_ff
);
    reg [AW-1:0] mem [0:DEPTH-1];

    // Storage has no reset; the pointer wraps like the real stack does on overflow.
    always @(posedge clk_i) begin
        if (push_i) begin
            mem[ptr_ff] <= push_data_i;
        end
    end

    // Pointer and registered top copy.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_ff <= {PW{1'b0}};
            top_ff <= {AW{1'b0}};
        end else if (push_i) begin
            ptr_ff <= ptr_ff + 1'b1;
            top_ff <= push_data_i;
        end
    end
endmodule // acx_stack
`default_nettype wire

// ---- design/acx_exec.v ----
`timescale 1ns/10ps
`default_nettype none
`include "acx_regs.vh"
// Operation
// RL1 - AND memory into accumulator, zero flag only
// RL2 - AND immediate into accumulator, zero flag only
// RL3 - AND accumulator into memory, accumulator kept
// RL4 - Call pushes instruction pointer plus one
// RL5 - Call loads target address, flags unchanged
// RL6 - Clear writes zero to memory, flags kept
// RL7 - Writes to pointer low byte add cycle
// RL8 - Eight-bit AND, zero flag means all-zero
module acx_exec #(
    parameter AW       = 12,
    parameter IPL_ADDR = 8'h06
) (
    // Clock and reset.
    input  wire          clk_i,
    input  wire          arst_n_i,
    // Instruction request.
    input  wire          start_i,
    input  wire [2:0]    op_sel_i,
    input  wire [7:0]    mem_addr_i,
    input  wire [7:0]    imm_i,
    input  wire [AW-1:0] target_i,
    input  wire [7:0]    mem_rdata_i,
    // Architectural state out.
    output reg  [7:0]    acc_ff,
    output reg           zero_flag_ff,
    output reg  [AW-1:0] instruction_pointer_ff,
    // Data memory write.
    output reg           mem_we_ff,
    output reg  [7:0]    mem_waddr_ff,
    output reg  [7:0]    mem_wdata_ff,
    // Stack view and completion.
    output wire [AW-1:0] stack_top_o,
    output wire [2:0]    stack_ptr_o,
    output reg           busy_ff,
    output reg           done_ff
);
    // Sequencer states; the whole instruction is one run of the counter.
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    // Counter width covers the longest instruction, two cycles of four clocks.
    localparam CW      = 4;

    // Sequencer state and the request fields held while it runs.
    reg          state_ff;
    reg [CW-1:0] cnt_ff;
    reg [2:0]    op_ff;
    // Push request and its payload, one clock behind the accepted call.
    reg          push_ff;
    reg [AW-1:0] push_data_ff;
    reg [AW-1:0] tgt_ff;

    // Eight-bit AND result plus all-zero test.
    function [8:0] and_z;
        input [7:0] a;
        input [7:0] b;
        reg   [7:0] r;
        begin
            r = a & b; // RL8
            and_z = {(r == `ACX_ZERO_BYTE), r}; // RL8
        end
    endfunction

    // True for the two operations that write the data memory.
    function mem_write;
        input [2:0] op;
        begin
            mem_write = (op == `ACX_OP_AND_TO_M) || (op == `ACX_OP_CLR_MEM);
        end
    endfunction

    // Instruction length in clocks, stretched when low pointer byte is written.
    function [CW-1:0] clocks;
        input [2:0]  op;
        input [7:0]  addr;
        reg   [31:0] n;
        begin
            if (op == `ACX_OP_CALL) begin
                n = `ACX_CALL_ICYC * `ACX_CLK_PER_ICYC;
            end else if (mem_write(op) && addr == IPL_ADDR) begin
                n = (`ACX_BASE_ICYC + `ACX_EXTRA_ICYC) * `ACX_CLK_PER_ICYC; // RL7
            end else begin
                n = `ACX_BASE_ICYC * `ACX_CLK_PER_ICYC;
            end
            // The product is small, so only the low bits are kept, on purpose.
            clocks = n[CW-1:0];
        end
    endfunction

    // Request decode; a request while the sequencer runs is dropped without notice.
    wire       take      = start_i && (state_ff == ST_IDLE);
    wire       take_wr   = take && mem_write(op_sel_i);
    wire       take_call = take && (op_sel_i == `ACX_OP_CALL);
    wire       last_clk  = (state_ff == ST_RUN) && (cnt_ff == {CW{1'b0}});
    wire [8:0] az_mem    = and_z(acc_ff, mem_rdata_i);
    wire [8:0] az_imm    = and_z(acc_ff, imm_i);

    // Sequencer: data effects land at the taking edge, the counter then holds the core off.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= {CW{1'b0}};
            op_ff    <= `ACX_OP_NONE;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (start_i) begin
                        state_ff <= ST_RUN;
                        busy_ff  <= 1'b1;
                        op_ff    <= op_sel_i;
                        cnt_ff   <= clocks(op_sel_i, mem_addr_i) - 1'b1;
                    end
                end
                ST_RUN: begin
                    // The done pulse and the idle state come together, so a new
                    // request may already sit on the bus during the pulse.
                    if (last_clk) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                        done_ff  <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Accumulator and zero flag; only the three AND operations touch them.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_ff       <= `ACX_ACC_RST;
            zero_flag_ff <= 1'b0;
        end else if (take) begin
            case (op_sel_i)
                `ACX_OP_AND_MEM: begin
                    acc_ff       <= az_mem[7:0]; // RL1
                    zero_flag_ff <= az_mem[8]; // RL1
                end
                `ACX_OP_AND_IMM: begin
                    acc_ff       <= az_imm[7:0]; // RL2
                    zero_flag_ff <= az_imm[8]; // RL2
                end
                `ACX_OP_AND_TO_M: begin
                    // The accumulator keeps its value; only the flag follows the result.
                    zero_flag_ff <= az_mem[8]; // RL3
                end
                default: begin
                    acc_ff <= acc_ff; // RL5
                end
            endcase
        end
    end

    // Data memory write port; the strobe is a single-clock pulse.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_we_ff    <= 1'b0;
            mem_waddr_ff <= 8'h00;
            mem_wdata_ff <= `ACX_ZERO_BYTE;
        end else begin
            mem_we_ff <= take_wr; // RL3
            if (take_wr) begin
                mem_waddr_ff <= mem_addr_i;
                if (op_sel_i == `ACX_OP_CLR_MEM) begin
                    mem_wdata_ff <= `ACX_ZERO_BYTE; // RL6
                end else begin
                    mem_wdata_ff <= az_mem[7:0]; // RL3
                end
            end
        end
    end

    // Return address push, issued one clock after the call is taken.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            push_ff      <= 1'b0;
            push_data_ff <= `ACX_IP_RST;
            tgt_ff       <= `ACX_IP_RST;
        end else begin
            push_ff <= take_call; // RL4
            if (take_call) begin
                push_data_ff <= instruction_pointer_ff + 1'b1; // RL4
                tgt_ff       <= target_i;
            end
        end
    end

    // Jump on the same edge as the push; its payload was taken from the old pointer at the taking edge; others step at the end.
    // A write to the low pointer byte only stretches the instruction here; the byte
    // itself is not merged into the pointer, which is left to the surrounding core.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instruction_pointer_ff <= `ACX_IP_RST;
        end else if (push_ff) begin
            instruction_pointer_ff <= tgt_ff; // RL5
        end else if (last_clk && (op_ff != `ACX_OP_CALL)) begin
            instruction_pointer_ff <= instruction_pointer_ff + 1'b1;
        end
    end

    // Return stack; it only grows here, as nothing in this block returns.
    acx_stack #(
        .AW(AW), .DEPTH(8), .PW(3)
    ) acx_stack_inst (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .push_i      (push_ff),
        .push_data_i (push_data_ff),
        .top_ff      (stack_top_o),
        .ptr_ff      (stack_ptr_o)
    );
endmodule // acx_exec
`default_nettype wire

// ---- tb/acx_exec_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
// Ties the accepted AND, call and clear requests to their results; timing goes unchecked for writes to other than the low pointer byte.
module acx_exec_checker #(
    parameter AW       = 12,
    parameter IPL_ADDR = 8'h06
) (
    // Clock, reset and request.
    input wire logic          clk_i,
    input wire logic          arst_n_i,
    input wire logic          start_i,
    input wire logic [2:0]    op_sel_i,
    input wire logic [7:0]    mem_addr_i,
    input wire logic [7:0]    imm_i,
    input wire logic [AW-1:0] target_i,
    input wire logic [7:0]    mem_rdata_i,
    // State and results.
    input wire logic [7:0]    acc_ff,
    input wire logic          zero_flag_ff,
    input wire logic [AW-1:0] instruction_pointer_ff,
    input wire logic          mem_we_ff,
    input wire logic [7:0]    mem_waddr_ff,
    input wire logic [7:0]    mem_wdata_ff,
    input wire logic [AW-1:0] stack_top_o,
    input wire logic [2:0]    stack_ptr_o,
    input wire logic          busy_ff,
    input wire logic          done_ff
);
    // A request while busy is ignored, so only this one starts an instruction.
    wire go = start_i & ~busy_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Completion after one and after two instruction cycles.
    sequence short_s; !done_ff [*4] ##1 done_ff; endsequence
    sequence long_s; !done_ff [*8] ##1 done_ff; endsequence
    and_mem_a: assert property (go && op_sel_i == 3'h1 |=> acc_ff == $past(acc_ff & mem_rdata_i)
        && zero_flag_ff == (acc_ff == 8'h00)) else $error("and to acc wrong");
    and_time_a: assert property (go && op_sel_i inside {3'h1, 3'h2} |=> short_s)
        else $error("and timing wrong");
    and_imm_a: assert property (go && op_sel_i == 3'h2 |=> acc_ff == $past(acc_ff & imm_i)
        && zero_flag_ff == (acc_ff == 8'h00)) else $error("and immediate wrong");
    and_nowr_a: assert property (go && op_sel_i inside {3'h1, 3'h2} |=> !mem_we_ff)
        else $error("and to acc wrote memory");
    wr_addr_a: assert property (go && op_sel_i inside {3'h3, 3'h5}
        |=> mem_waddr_ff == $past(mem_addr_i)) else $error("write address wrong");
    call_flags_a: assert property (go && op_sel_i == 3'h4
        |=> $stable(zero_flag_ff) && $stable(acc_ff) && !mem_we_ff) else $error("call side effect");
    push_ptr_a: assert property (go && op_sel_i == 3'h4 |-> ##2
        stack_ptr_o == $past(stack_ptr_o, 2) + 3'h1) else $error("stack pointer wrong");
    and_tom_a: assert property (go && op_sel_i == 3'h3 |=> mem_we_ff && $stable(acc_ff)
        && mem_wdata_ff == $past(acc_ff & mem_rdata_i)) else $error("and to mem wrong");
    clr_mem_a: assert property (go && op_sel_i == 3'h5 |=> mem_we_ff && mem_wdata_ff == 8'h00
        && $stable(zero_flag_ff)) else $error("clear wrong");
    call_push_a: assert property (go && op_sel_i == 3'h4 |-> ##2
        stack_top_o == $past(instruction_pointer_ff, 2) + 1'b1) else $error("push wrong");
    call_jump_a: assert property (go && op_sel_i == 3'h4 |-> ##2
        instruction_pointer_ff == $past(target_i, 2)) else $error("jump wrong");
    call_time_a: assert property (go && op_sel_i == 3'h4 |=> long_s)
        else $error("call timing wrong");
    low_ptr_a: assert property (go && op_sel_i inside {3'h3, 3'h5} && mem_addr_i == IPL_ADDR
        |=> long_s) else $error("extra cycle missing");
endmodule // acx_exec_checker
bind acx_exec acx_exec_checker #(.AW(AW), .IPL_ADDR(IPL_ADDR)) acx_exec_checker_inst (
    .clk_i                  (clk_i),
    .arst_n_i               (arst_n_i),
    .start_i                (start_i),
    .op_sel_i               (op_sel_i),
    .mem_addr_i             (mem_addr_i),
    .imm_i                  (imm_i),
    .target_i               (target_i),
    .mem_rdata_i            (mem_rdata_i),
    .acc_ff                 (acc_ff),
    .zero_flag_ff           (zero_flag_ff),
    .instruction_pointer_ff (instruction_pointer_ff),
    .mem_we_ff              (mem_we_ff),
    .mem_waddr_ff           (mem_waddr_ff),
    .mem_wdata_ff           (mem_wdata_ff),
    .stack_top_o            (stack_top_o),
    .stack_ptr_o            (stack_ptr_o),
    .busy_ff                (busy_ff),
    .done_ff                (done_ff)
);
`default_nettype wire

// ---- tb/and_call_clear_exec_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acx_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
// Issues single instructions and judges them at the executor's ports.
module and_call_clear_exec_tb_top;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0;
    logic [2:0]  op_sel_i = 3'h0;
    logic [7:0]  mem_addr_i = 8'h00, imm_i = 8'h00, mem_rdata_i = 8'h00, wd, wa;
    logic [11:0] target_i = 12'h000, p;
    wire  [7:0]  acc_ff, mem_waddr_ff, mem_wdata_ff;
    wire  [11:0] instruction_pointer_ff, stack_top_o;
    wire  [2:0]  stack_ptr_o;
    wire         zero_flag_ff, mem_we_ff, busy_ff, done_ff;
    int          mismatches = 0, n_checks = 0, n;
    acx_exec acx_exec_inst (
        .clk_i                  (clk_i),
        .arst_n_i               (arst_n_i),
        .start_i                (start_i),
        .op_sel_i               (op_sel_i),
        .mem_addr_i             (mem_addr_i),
        .imm_i                  (imm_i),
        .target_i               (target_i),
        .mem_rdata_i            (mem_rdata_i),
        .acc_ff                 (acc_ff),
        .zero_flag_ff           (zero_flag_ff),
        .instruction_pointer_ff (instruction_pointer_ff),
        .mem_we_ff              (mem_we_ff),
        .mem_waddr_ff           (mem_waddr_ff),
        .mem_wdata_ff           (mem_wdata_ff),
        .stack_top_o            (stack_top_o),
        .stack_ptr_o            (stack_ptr_o),
        .busy_ff                (busy_ff),
        .done_ff                (done_ff)
    );
    // Free-running system clock.
    always #50 clk_i = ~clk_i;
    task stop_test;
        $display("mismatches %0d checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One request; n ends as the edge count to done, wd as the byte written if any.
    task run(input logic [2:0] op, input logic [7:0] a, input logic [11:0] t);
        p = instruction_pointer_ff;
        @(posedge clk_i);
        start_i <= 1'b1;
        op_sel_i <= op;
        mem_addr_i <= a;
        target_i <= t;
        mem_rdata_i <= 8'hC3;
        @(posedge clk_i);
        start_i <= 1'b0;
        wd = 8'hEE;
        wa = 8'hEE;
        for (n = 0; n < 20; n++) begin
            @(negedge clk_i);
            if (mem_we_ff === 1'b1) begin
                wd = mem_wdata_ff;
                wa = mem_waddr_ff;
            end
            if (done_ff === 1'b1) break;
            @(posedge clk_i);
        end
        if (n == 20) begin
            mismatches++;
            stop_test();
        end
    endtask
    // Clear runs first, while the zero flag is still low, so a flag change shows.
    task t_clear;
        run(`ACX_OP_CLR_MEM, 8'h10, 12'h000);
        `CHK(wd, 8'h00)
        `CHK(wa, 8'h10)
        `CHK(zero_flag_ff, 1'b0)
        `CHK(instruction_pointer_ff, p + 12'h001)
    endtask
    // The accumulator resets to zero, so every AND result is zero.
    task t_and;
        run(`ACX_OP_AND_MEM, 8'h11, 12'h000);
        `CHK(acc_ff, 8'h00)
        `CHK(zero_flag_ff, 1'b1)
        `CHK(n, 4)
        @(posedge clk_i);
        imm_i <= 8'hFF;
        run(`ACX_OP_AND_IMM, 8'h12, 12'h000);
        `CHK(wd, 8'hEE)
        `CHK(acc_ff, 8'h00)
        `CHK(zero_flag_ff, 1'b1)
        run(`ACX_OP_AND_TO_M, 8'h20, 12'h000);
        `CHK(wd, 8'h00)
        `CHK(wa, 8'h20)
        `CHK(zero_flag_ff, 1'b1)
        `CHK(n, 4)
    endtask
    // Writes aimed at the pointer low byte take a second instruction cycle.
    task t_low_ptr;
        run(`ACX_OP_CLR_MEM, 8'h06, 12'h000);
        `CHK(n, 8)
        `CHK(wa, 8'h06)
        run(`ACX_OP_AND_TO_M, 8'h06, 12'h000);
        `CHK(n, 8)
    endtask
    // Two calls back to back; each pushes its own return address.
    task t_call;
        for (int i = 1; i < 3; i++) begin
            run(`ACX_OP_CALL, 8'h00, 12'hAB0 + i[11:0]);
            `CHK(stack_top_o, p + 12'h001)
            `CHK(stack_ptr_o, i[2:0])
            `CHK(instruction_pointer_ff, 12'hAB0 + i[11:0])
            `CHK(zero_flag_ff, 1'b1)
            `CHK(n, 8)
        end
    endtask
    // Reset for eight clocks, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_clear();
        t_and();
        t_low_ptr();
        t_call();
        stop_test();
    end
endmodule // and_call_clear_exec_tb_top
`default_nettype wire
